// File: rtl/psm_pkg.sv
// Constants and types shared by the power saving mode controller.
// Assumes one clock, clk_sys, and an APB register port with 32-bit data.
package psm_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] PSM_MISC_CTRL_OFS = 8'h00;
  localparam logic [7:0] PSM_CLK_STAT_OFS = 8'h04;
  localparam logic [7:0] PSM_MODE_STAT_OFS = 8'h08;
  localparam int PSM_SMS_BIT = 0;
  localparam int PSM_SEL_LSB = 1;
  localparam int PSM_OIE_BIT = 0;
  localparam logic PSM_SMS_RST = 1'b0;
  localparam logic [1:0] PSM_SEL_RST = 2'h0;
  localparam logic PSM_OIE_RST = 1'b0;

  // ==========================================================
  // Clock division and timing
  // A ratio code r divides the oscillator by 2 to the power r+1.
  localparam logic [2:0] PSM_RATIO_NORMAL = 3'h0;
  localparam logic [2:0] PSM_RATIO_SLOW_BASE = 3'h1;
  localparam int PSM_STARTUP_CYCLES = 4096;
  localparam logic [11:0] PSM_STARTUP_LAST = 12'(PSM_STARTUP_CYCLES - 1);

  // Interrupt mask pattern that enables all interrupts.
  localparam logic [1:0] PSM_CC_MASK_ENABLE = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [2:0]
  {
    PSM_RUN,
    PSM_WAIT,
    PSM_AHALT,
    PSM_HALT,
    PSM_START
  } psm_state_e;

  typedef struct packed {
    logic wfi_exec;
    logic halt_exec;
    logic irq_pending;
    logic halt_irq_pending;
    logic tb_irq;
  } psm_core_s;

  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic tb_clk_en;
    logic osc_enable;
  } psm_clk_s;

endpackage

// File: rtl/psm_clk_div.sv
// Oscillator divider that makes the core clock tick.
// Assumes clk_sys is the oscillator clock and ratio changes are rare.
`timescale 1ns/1ps
module psm_clk_div
(
  input wire logic clk_sys, // Oscillator clock.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic run, // Oscillator running.
  input wire logic [2:0] ratio, // Divide by 2 to the power ratio+1.
  output logic tick // One pulse per core clock cycle.
);
  import psm_pkg::*;

  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic [4:0] last;
  logic next_tick;

  // ==========================================================
  // Divider count
  // The compare is greater-or-equal so a smaller ratio never overruns.
  always_comb
  begin
    last = 5'((6'h2 << ratio) - 6'h1);
    next_tick = 1'b0;
    next_cnt = 5'h0;
    if (run)
    begin
      if (cnt >= last)
      begin
        next_tick = 1'b1;
      end
      else
      begin
        next_cnt = cnt + 5'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt <= 5'h0;
      tick <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end

endmodule

// File: rtl/psm_ctrl.sv
// Power saving mode controller: run, slow, wait, active-halt and halt.
// Assumes the core pulses its instruction strobes for one clk_sys cycle.
// Operation
// - After reset run normally with the oscillator divided by two.
// - Slow mode divides the oscillator by 4, 8, 16 or 32 per select.
// - Wait entered in slow mode keeps the slow rate.
// - Wait stops the CPU clock while peripherals keep running.
// - Entering wait forces the interrupt mask bits to 10.
// - Wait ends only on an interrupt or a reset.
// - The wake interrupt is serviced with the condition code pushed.
// - Halt instruction picks active-halt if the time-base enable is set.
// - Active-halt clocks only the oscillator and the time base.
// - Active-halt ends on time-base, halt-capable interrupt or reset.
// - Leaving active-halt waits 4096 CPU cycles before resuming.
// - Entering active-halt forces mask 10; pending interrupts wake at once.
// - Active-halt with the watchdog running gives no watchdog reset.
// - Full halt turns the oscillator off.
// - Leaving full halt restarts the oscillator then waits 4096 cycles.
// - Entering full halt enables interrupts; pending ones wake at once.
// - Halt with the watchdog on may reset, per the halt option bit.
`timescale 1ns/1ps
module psm_ctrl
(
  input wire logic clk_sys, // System clock, 250 MHz.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped address.
  input wire psm_pkg::psm_core_s core_in, // Strobes from the core.
  input wire logic ext_wake_pin, // Halt-capable external interrupt.
  input wire logic wdg_enabled, // Watchdog running.
  input wire logic wdg_halt_opt_pin, // Option bit, 1 lets halt pass.
  output psm_pkg::psm_clk_s clk_out, // Clock enables and oscillator.
  output logic [1:0] cc_mask, // Interrupt mask value to load.
  output logic cc_mask_load, // Load cc_mask into the core.
  output logic irq_service, // Push condition code, take interrupt.
  output logic reset_fetch, // Fetch the reset vector.
  output logic wdg_reset_req // Watchdog reset request.
);
  import psm_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] pins;
  assign pins = {wdg_halt_opt_pin, ext_wake_pin};

  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_sync
      always_ff @(posedge clk_sys or negedge resetn)
      begin
        if (!resetn)
        begin
          sync1[i] <= 1'b0;
          sync2[i] <= 1'b0;
        end
        else
        begin
          sync1[i] <= pins[i];
          sync2[i] <= sync1[i];
        end
      end
    end
  endgenerate

  logic ext_wake;
  logic wdg_halt_opt;
  assign ext_wake = sync2[0];
  assign wdg_halt_opt = sync2[1];

  // ==========================================================
  // APB registers
  logic slow_mode_enable_bit;
  logic [1:0] sel;
  logic oscillator_interrupt_enable;
  logic next_sms;
  logic [1:0] next_sel;
  logic next_oie;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic hit;
  logic do_write;
  psm_state_e state;
  logic wake_irq;
  logic osc_en;

  always_comb
  begin
    next_sms = slow_mode_enable_bit;
    next_sel = sel;
    next_oie = oscillator_interrupt_enable;
    next_prdata = 32'h0;
    hit = (paddr == PSM_MISC_CTRL_OFS) || (paddr == PSM_CLK_STAT_OFS)
      || (paddr == PSM_MODE_STAT_OFS);
    next_pready = psel && !penable;
    next_pslverr = psel && !penable && !hit;
    do_write = psel && penable && pready && pwrite;
    if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        PSM_MISC_CTRL_OFS:
          next_prdata = {29'h0, sel, slow_mode_enable_bit};
        PSM_CLK_STAT_OFS:
          next_prdata = {31'h0, oscillator_interrupt_enable};
        PSM_MODE_STAT_OFS:
          next_prdata = {27'h0, wake_irq, osc_en, 3'(state)};
        default:
          next_prdata = 32'h0;
      endcase
    end
    if (do_write && paddr == PSM_MISC_CTRL_OFS)
    begin
      next_sms = pwdata[PSM_SMS_BIT];
      next_sel = pwdata[PSM_SEL_LSB +: 2];
    end
    if (do_write && paddr == PSM_CLK_STAT_OFS)
    begin
      next_oie = pwdata[PSM_OIE_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      slow_mode_enable_bit <= PSM_SMS_RST;
      sel <= PSM_SEL_RST;
      oscillator_interrupt_enable <= PSM_OIE_RST;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      slow_mode_enable_bit <= next_sms;
      sel <= next_sel;
      oscillator_interrupt_enable <= next_oie;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================
  // Core clock divider
  // The ratio does not depend on the mode, so wait keeps the slow rate.
  logic [2:0] ratio;
  logic tick;
  assign ratio = slow_mode_enable_bit ? 3'(PSM_RATIO_SLOW_BASE + sel)
    : PSM_RATIO_NORMAL;

  psm_clk_div u_div
  (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .run(osc_en),
    .ratio(ratio),
    .tick(tick)
  );

  // ==========================================================
  // Mode sequencer
  logic [11:0] cnt;
  logic [11:0] next_cnt;
  psm_state_e next_state;
  logic next_wake_irq;
  logic next_osc_en;
  logic [1:0] next_cc_mask;
  logic next_cc_load;
  logic next_irq_svc;
  logic next_rst_fetch;
  logic next_wdg_rst;
  psm_clk_s next_clk;
  logic halt_wake;
  logic ahalt_wake;

  assign halt_wake = core_in.halt_irq_pending || ext_wake;
  assign ahalt_wake = halt_wake || core_in.tb_irq;

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_wake_irq = wake_irq;
    next_osc_en = osc_en;
    next_cc_mask = cc_mask;
    next_cc_load = 1'b0;
    next_irq_svc = 1'b0;
    next_rst_fetch = 1'b0;
    next_wdg_rst = 1'b0;
    unique case (state)
      PSM_RUN:
        if (core_in.halt_exec)
        begin
          if (oscillator_interrupt_enable)
          begin
            next_state = PSM_AHALT;
            next_cc_load = 1'b1;
            next_cc_mask = PSM_CC_MASK_ENABLE;
          end
          else if (wdg_enabled && !wdg_halt_opt)
          begin
            next_wdg_rst = 1'b1;
          end
          else
          begin
            next_state = PSM_HALT;
            next_osc_en = 1'b0;
            next_cc_load = 1'b1;
            next_cc_mask = PSM_CC_MASK_ENABLE;
          end
        end
        else if (core_in.wfi_exec)
        begin
          next_state = PSM_WAIT;
          next_cc_load = 1'b1;
          next_cc_mask = PSM_CC_MASK_ENABLE;
        end
      PSM_WAIT:
        if (core_in.irq_pending)
        begin
          next_state = PSM_RUN;
          next_irq_svc = 1'b1;
        end
      PSM_AHALT:
        if (ahalt_wake)
        begin
          next_state = PSM_START;
          next_cnt = 12'h0;
          next_wake_irq = 1'b1;
        end
      PSM_HALT:
        if (halt_wake)
        begin
          next_state = PSM_START;
          next_osc_en = 1'b1;
          next_cnt = 12'h0;
          next_wake_irq = 1'b1;
        end
      PSM_START:
        if (tick)
        begin
          if (cnt == PSM_STARTUP_LAST)
          begin
            next_state = PSM_RUN;
            next_irq_svc = wake_irq;
            next_rst_fetch = !wake_irq;
            next_wake_irq = 1'b0;
          end
          else
          begin
            next_cnt = cnt + 12'h1;
          end
        end
    endcase
    next_clk.cpu_clk_en = tick && (state == PSM_RUN);
    next_clk.periph_clk_en = tick
      && (state == PSM_RUN || state == PSM_WAIT);
    next_clk.tb_clk_en = tick;
    next_clk.osc_enable = next_osc_en;
  end

  // Reset lands in the start-up delay, ending in a reset vector fetch.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= PSM_START;
      cnt <= 12'h0;
      wake_irq <= 1'b0;
      osc_en <= 1'b1;
      cc_mask <= PSM_CC_MASK_ENABLE;
      cc_mask_load <= 1'b0;
      irq_service <= 1'b0;
      reset_fetch <= 1'b0;
      wdg_reset_req <= 1'b0;
      clk_out <= '0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      wake_irq <= next_wake_irq;
      osc_en <= next_osc_en;
      cc_mask <= next_cc_mask;
      cc_mask_load <= next_cc_load;
      irq_service <= next_irq_svc;
      reset_fetch <= next_rst_fetch;
      wdg_reset_req <= next_wdg_rst;
      clk_out <= next_clk;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  wait_entry_a: assert property (
    state == PSM_RUN && core_in.wfi_exec && !core_in.halt_exec
    |=> state == PSM_WAIT && cc_mask_load
      && cc_mask == PSM_CC_MASK_ENABLE)
    else $error("wait entry without mask load");

  wait_cpu_a: assert property (
    state == PSM_WAIT && $past(state) == PSM_WAIT
    |-> !clk_out.cpu_clk_en && clk_out.periph_clk_en == $past(tick))
    else $error("wait clocks wrong");

  wait_exit_a: assert property (
    state == PSM_WAIT && !core_in.irq_pending |=> state == PSM_WAIT)
    else $error("wait left without interrupt");

  ahalt_pick_a: assert property (
    state == PSM_RUN && core_in.halt_exec && oscillator_interrupt_enable
    |=> state == PSM_AHALT && !wdg_reset_req)
    else $error("active halt not entered");

  ahalt_gate_a: assert property (
    state == PSM_AHALT && $past(state) == PSM_AHALT
    |-> !clk_out.cpu_clk_en && !clk_out.periph_clk_en
      && clk_out.osc_enable)
    else $error("active halt clocks wrong");

  ahalt_hold_a: assert property (
    state == PSM_AHALT && !ahalt_wake |=> state == PSM_AHALT)
    else $error("active halt left without wake");

  halt_osc_a: assert property (
    state == PSM_HALT |-> !osc_en ##1 (state != PSM_HALT || !tick))
    else $error("oscillator runs in halt");

  halt_wake_a: assert property (
    state == PSM_HALT && halt_wake
    |=> state == PSM_START && clk_out.osc_enable && cnt == 12'h0)
    else $error("halt wake did not restart oscillator");

  startup_len_a: assert property (
    $past(state) == PSM_START && state == PSM_RUN
    |-> $past(cnt) == PSM_STARTUP_LAST && (irq_service ^ reset_fetch))
    else $error("start-up delay ended early");

  wdg_halt_a: assert property (
    state == PSM_RUN && core_in.halt_exec && !oscillator_interrupt_enable && wdg_enabled
    && !wdg_halt_opt |=> wdg_reset_req && state == PSM_RUN)
    else $error("watchdog reset missing on halt");

endmodule

// File: dv/psm_core_model.sv
// Core model: instruction strobes, interrupt levels and the CC mask.
// Assumes its tasks are called from the clk_sys domain.
`timescale 1ns/1ps
module psm_core_model
(
  input wire logic clk_sys, // System clock.
  input wire logic [1:0] cc_mask, // Mask value offered.
  input wire logic cc_mask_load, // Mask load strobe.
  input wire logic irq_service, // Interrupt entry strobe.
  output psm_pkg::psm_core_s core // Strobes and levels.
);
  import psm_pkg::*;
  logic [1:0] cc = 2'h3;
  logic [1:0] stack = 2'h0;
  initial core = '0;
  // ========
  // Mask and stack
  always @(posedge clk_sys)
  begin
    if (cc_mask_load)
      cc <= cc_mask;
    if (irq_service)
    begin
      stack <= cc;
      cc <= 2'h1;
    end
  end
  task pulse(input logic halt);
    @(posedge clk_sys);
    core.halt_exec <= halt;
    core.wfi_exec <= !halt;
    @(posedge clk_sys);
    core.halt_exec <= 1'b0;
    core.wfi_exec <= 1'b0;
  endtask
  task irqs(input logic [2:0] v);
    @(posedge clk_sys);
    {core.irq_pending, core.halt_irq_pending, core.tb_irq} <= v;
  endtask
endmodule

// File: dv/power_saving_mode_control_bench.sv
// Bench for the power saving mode controller.
// Assumes psm_ctrl and the core model; no other parts.
`timescale 1ns/1ps
module power_saving_mode_control_bench;
  import psm_pkg::*;
  logic clk_sys;
  logic resetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, cc_mask_load, irq_service;
  logic reset_fetch, wdg_reset_req;
  logic ext_wake_pin;
  logic wdg_enabled;
  logic wdg_halt_opt_pin;
  logic [1:0] cc_mask;
  psm_core_s core_in;
  psm_clk_s clk_out;
  int errors = 0;
  int samples_checked = 0;
  int wdg_seen = 0;
  int n;

  psm_ctrl i_dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_in(core_in), .ext_wake_pin(ext_wake_pin),
    .wdg_enabled(wdg_enabled), .wdg_halt_opt_pin(wdg_halt_opt_pin),
    .clk_out(clk_out), .cc_mask(cc_mask), .cc_mask_load(cc_mask_load),
    .irq_service(irq_service), .reset_fetch(reset_fetch),
    .wdg_reset_req(wdg_reset_req));
  psm_core_model i_core (.clk_sys(clk_sys), .cc_mask(cc_mask),
    .cc_mask_load(cc_mask_load), .irq_service(irq_service),
    .core(core_in));

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
    if (wdg_reset_req)
      wdg_seen++;

  // ========
  // Shared tasks
  task chk(input string name, input logic [31:0] seen,
           input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task conclude;
    $display("compares %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task tick;
    @(posedge clk_sys);
    #1;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Counts cycles until the chosen strobe shows, bounded.
  task wait_ev(input int w, output int c);
    c = 0;
    do
    begin
      tick;
      c++;
    end
    while ((w == 0 ? reset_fetch : irq_service) !== 1'b1 && c < 9000);
  endtask
  // Cycles from one clock enable pulse to the next.
  task period(input logic pe, output int p);
    for (int i = 0; i < 2; i++)
    begin
      p = 0;
      do
      begin
        tick;
        p++;
      end
      while ((pe ? clk_out.periph_clk_en : clk_out.cpu_clk_en) !== 1'b1
             && p < 100);
    end
  endtask

  // ========
  // Scenarios
  task t_reset;
    apb(1'b0, PSM_MODE_STAT_OFS, 32'h0);
    chk("start state", rd[3:0], 4'hc);
    wait_ev(0, n);
    chk("startup len", n > 8180 && n < 8200, 1'b1);
    period(1'b0, n);
    chk("run div", n, 2);
    $display("reset done");
  endtask
  task t_slow;
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, PSM_MISC_CTRL_OFS, 32'(s * 2 + 1));
      period(1'b0, n);
      period(1'b0, n);
      chk("slow div", n, 4 << s);
    end
    i_core.pulse(1'b0);
    tick;
    chk("wait mask", i_core.cc, 2'h2);
    period(1'b1, n);
    chk("slow wait", n, 32);
    chk("cpu stop", clk_out.cpu_clk_en, 1'b0);
    i_core.irqs(3'h4);
    wait_ev(1, n);
    chk("wait wake", n, 1);
    tick;
    chk("cc pushed", i_core.stack, 2'h2);
    i_core.irqs(3'h0);
    apb(1'b1, PSM_MISC_CTRL_OFS, 32'h0);
    $display("slow and wait done");
  endtask
  task t_halt;
    apb(1'b1, PSM_CLK_STAT_OFS, 32'h0);
    i_core.pulse(1'b1);
    i_core.irqs(3'h1);
    apb(1'b0, PSM_MODE_STAT_OFS, 32'h0);
    chk("halt state", rd[3:0], 4'h3);
    chk("halt osc", clk_out.osc_enable, 1'b0);
    chk("halt mask", i_core.cc, 2'h2);
    @(posedge clk_sys);
    ext_wake_pin <= 1'b1;
    wait_ev(1, n);
    chk("halt wake", n > 8185 && n < 8205, 1'b1);
    chk("osc back", clk_out.osc_enable, 1'b1);
    ext_wake_pin <= 1'b0;
    i_core.irqs(3'h0);
    $display("halt done");
  endtask
  task t_ahalt;
    int k;
    int m;
    k = 0;
    m = 0;
    apb(1'b1, PSM_CLK_STAT_OFS, 32'h1);
    wdg_enabled <= 1'b1;
    wdg_halt_opt_pin <= 1'b0;
    i_core.pulse(1'b1);
    i_core.irqs(3'h4);
    apb(1'b0, PSM_MODE_STAT_OFS, 32'h0);
    chk("ahalt state", rd[3:0], 4'ha);
    chk("ahalt mask", i_core.cc, 2'h2);
    repeat (16)
    begin
      tick;
      k += clk_out.tb_clk_en;
      m += clk_out.periph_clk_en;
    end
    chk("tb runs", k, 8);
    chk("periph off", m, 0);
    i_core.irqs(3'h5);
    wait_ev(1, n);
    chk("ahalt wake", n > 8185 && n < 8205, 1'b1);
    chk("no wdg", wdg_seen, 0);
    i_core.irqs(3'h0);
    $display("active halt done");
  endtask
  task t_wdg;
    apb(1'b1, PSM_CLK_STAT_OFS, 32'h0);
    i_core.pulse(1'b1);
    repeat (4) tick;
    chk("wdg reset", wdg_seen, 1);
    apb(1'b0, PSM_MODE_STAT_OFS, 32'h0);
    chk("still run", rd[3:0], 4'h8);
    @(posedge clk_sys);
    wdg_halt_opt_pin <= 1'b1;
    i_core.irqs(3'h2);
    repeat (4) tick;
    i_core.pulse(1'b1);
    wait_ev(1, n);
    chk("pend wake", n > 8185 && n < 8205, 1'b1);
    i_core.irqs(3'h0);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped err", er, 1'b1);
    chk("unmapped data", rd, 32'h0);
    $display("watchdog done");
  endtask

  initial
  begin
    #200000;
    errors++;
    conclude;
  end
  initial
  begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_wake_pin = 1'b0;
    wdg_enabled = 1'b0;
    wdg_halt_opt_pin = 1'b1;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset;
    t_slow;
    t_halt;
    t_ahalt;
    t_wdg;
    conclude;
  end
endmodule
